// ===== rtl/iprs_pkg.sv
// Purpose: constants and types shared by the register bank files
// Assumes: 8-bit register index, 32-bit data, one register per index
// Notes: undefined-state registers live in the store at IPRS_A_STORE
package iprs_pkg;
	localparam int IPRS_AW = 8;
	localparam int IPRS_DW = 32;
	localparam int IPRS_SW = 4;
	localparam int IPRS_DEPTH = 16;
	typedef logic [IPRS_DW-1:0] iprs_word_t;
	typedef logic [IPRS_AW-1:0] iprs_addr_t;
	typedef logic [IPRS_SW-1:0] iprs_idx_t;

	////////////////////////////////////////////////////////////////////
	// register index map
	localparam iprs_addr_t IPRS_A_PRIV_BASE = 8'h00;
	localparam iprs_addr_t IPRS_A_IU_CTL = 8'h01;
	localparam iprs_addr_t IPRS_A_PROC_CTX = 8'h02;
	localparam iprs_addr_t IPRS_A_DATA_CACHE_CONTROL = 8'h03;
	localparam iprs_addr_t IPRS_A_MU_CTL = 8'h04;
	localparam iprs_addr_t IPRS_A_TAG_A = 8'h05;
	localparam iprs_addr_t IPRS_A_TAG_B = 8'h06;
	localparam iprs_addr_t IPRS_A_ENT_A = 8'h07;
	localparam iprs_addr_t IPRS_A_ENT_B = 8'h08;
	localparam iprs_addr_t IPRS_A_ASN_A = 8'h09;
	localparam iprs_addr_t IPRS_A_ASN_B = 8'h0A;
	localparam iprs_addr_t IPRS_A_ITRANS_IA = 8'h0B;
	localparam iprs_addr_t IPRS_A_DTRANS_IA = 8'h0C;
	localparam iprs_addr_t IPRS_A_CACHE_CFG = 8'h0D;
	localparam iprs_addr_t IPRS_A_STATUS = 8'h0E;
	localparam iprs_addr_t IPRS_A_STORE = 8'h10;

	// store slots, all without reset
	localparam iprs_idx_t IPRS_U_HARDWARE_INTERRUPT_CLEAR = 4'h0;
	localparam iprs_idx_t IPRS_U_IU_STATUS = 4'h1;
	localparam iprs_idx_t IPRS_U_PERF_CTL = 4'h2;
	localparam iprs_idx_t IPRS_U_CYCLE_CNT = 4'h3;
	localparam iprs_idx_t IPRS_U_CYCLE_CTL = 4'h4;
	localparam iprs_idx_t IPRS_U_VIRTUAL_ADDRESS_CONTROL = 4'h5;
	localparam iprs_idx_t IPRS_U_DC_STATUS = 4'h6;
	localparam iprs_idx_t IPRS_U_INTERRUPT_ENABLE_CURRENT_MODE = 4'h7;
	localparam iprs_idx_t IPRS_U_ALT_MODE = 4'h8;
	localparam iprs_idx_t IPRS_U_CACHE_DATA = 4'h9;

	////////////////////////////////////////////////////////////////////
	// field positions and values after reset
	localparam int IPRS_ICE_LSB = 1;
	localparam logic [1:0] IPRS_ICE_RST = 2'h3;
	localparam int IPRS_FE_BIT = 2;
	localparam logic [7:0] IPRS_DCC_RST = 8'h03;
	localparam int IPRS_L2_BIT = 0;
	localparam int IPRS_ST_PG = 0;
	localparam int IPRS_ST_TRST = 1;
	localparam int IPRS_ST_SEQERR = 2;
	localparam iprs_word_t IPRS_ZERO = 32'h0000_0000;
	localparam iprs_word_t IPRS_IUC_RST = 32'h0000_0006;
	localparam iprs_word_t IPRS_PROCESS_CONTEXT_RST = 32'h0000_0004;
endpackage : iprs_pkg

// ===== rtl/iprs_store_if.sv
// Purpose: write and read path into the no-reset register store
// Assumes: one clock, read is combinational from the index
// Notes: ctrl side drives, store side answers
`timescale 1ns/10ps
interface iprs_store_if;
	logic we;
	iprs_pkg::iprs_idx_t idx;
	iprs_pkg::iprs_word_t wdata;
	iprs_pkg::iprs_word_t rdata;
	modport ctrl (output we, output idx, output wdata, input rdata);
	modport store (input we, input idx, input wdata, output rdata);
endinterface : iprs_store_if

// ===== rtl/iprs_undef_store.sv
// Purpose: flip-flop store for registers whose state after power-up is open
// Assumes: firmware writes each slot before it relies on it
// Notes: no reset on purpose; contents are unknown until written
`timescale 1ns/10ps
module iprs_undef_store (
	input wire logic i_mclk,
	input wire logic i_resetn,
	iprs_store_if.store bus
);
	import iprs_pkg::*;

	typedef struct packed {
		iprs_word_t [IPRS_DEPTH-1:0] mem;
	} iprs_store_st_t;

	iprs_store_st_t st;
	iprs_store_st_t next_st;

	always_comb begin
		next_st = st;
		if (bus.we) begin
			next_st.mem[bus.idx] = bus.wdata;
		end
	end

	// no reset branch: saves area, mirrors the open power-up state
	always_ff @(posedge i_mclk) begin
		st <= next_st;
	end

	assign bus.rdata = st.mem[bus.idx];

	property p_store_keeps;
		@(posedge i_mclk) disable iff (!i_resetn)
		bus.we |=> st.mem[$past(bus.idx)] == $past(bus.wdata);
	endproperty
	a_store_keeps: assert property (p_store_keeps)
		else $error("store slot lost a written value");
endmodule : iprs_undef_store

// ===== rtl/iprs_bank.sv
// Purpose: processor control register bank with defined power-up values
// Assumes: strobes from logic on i_mclk; resets and power good are pins
// Notes: warm reset clears a subset only; see warm branch below
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////
// Functional notes
// - many register bits may power up in any state, no defined value.
// - power-up loads instruction control with icache enable 3, rest 0.
// - power-up sets process context float enable, clears other bits.
// - reset clears data cache control bits 7 to 2.
// - power-up sets data cache control bits 1 and 0.
// - power-up clears translation tag, entry, space, memory, base regs.
// - test reset may stay asserted; device runs normally meanwhile.
// - warm reset clears base, instruction control, cache chain; sets fe.
module iprs_bank (
	input wire logic i_mclk,
	input wire logic i_resetn,
	input wire logic i_warm_reset,
	input wire logic i_test_resetn,
	input wire logic i_power_good,
	input wire iprs_pkg::iprs_addr_t i_addr,
	input wire iprs_pkg::iprs_word_t i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output iprs_pkg::iprs_word_t o_rdata,
	output logic [1:0] o_icache_enable,
	output logic [7:0] o_dcache_ctl,
	output logic o_l2_enable,
	output logic o_itrans_flush,
	output logic o_dtrans_flush
);
	import iprs_pkg::*;

	typedef struct packed {
		logic [1:0] warm_s;
		logic [1:0] trst_s;
		logic [1:0] pg_s;
		logic fresh;
		logic seq_err;
		iprs_word_t priv_base;
		iprs_word_t iu_ctl;
		iprs_word_t proc_ctx;
		logic [7:0] data_cache_control;
		iprs_word_t mu_ctl;
		iprs_word_t tag_a;
		iprs_word_t tag_b;
		iprs_word_t ent_a;
		iprs_word_t ent_b;
		iprs_word_t asn_a;
		iprs_word_t asn_b;
		iprs_word_t cache_cfg;
		iprs_word_t rdata;
		logic it_flush;
		logic dt_flush;
	} iprs_bank_st_t;

	iprs_bank_st_t st;
	iprs_bank_st_t next_st;
	iprs_store_if sbus ();
	logic wr_store;
	logic warm;
	iprs_word_t status;
	iprs_word_t rmux;

	iprs_undef_store u_store (
		.i_mclk (i_mclk),
		.i_resetn (i_resetn),
		.bus (sbus.store)
	);

	////////////////////////////////////////////////////////////////////
	// store access, firmware owns its contents
	assign wr_store = i_wr && (i_addr[IPRS_AW-1:IPRS_SW] ==
		IPRS_A_STORE[IPRS_AW-1:IPRS_SW]);
	assign sbus.we = wr_store;
	assign sbus.idx = i_addr[IPRS_SW-1:0];
	assign sbus.wdata = i_wdata;
	assign warm = st.warm_s[1];

	// test reset does not gate anything; it is only reported
	assign status = {29'h0000_0000, st.seq_err, st.trst_s[1], st.pg_s[1]};

	always_comb begin
		unique case (i_addr)
			IPRS_A_PRIV_BASE: rmux = st.priv_base;
			IPRS_A_IU_CTL: rmux = st.iu_ctl;
			IPRS_A_PROC_CTX: rmux = st.proc_ctx;
			IPRS_A_DATA_CACHE_CONTROL: rmux = {24'h00_0000, st.data_cache_control};
			IPRS_A_MU_CTL: rmux = st.mu_ctl;
			IPRS_A_TAG_A: rmux = st.tag_a;
			IPRS_A_TAG_B: rmux = st.tag_b;
			IPRS_A_ENT_A: rmux = st.ent_a;
			IPRS_A_ENT_B: rmux = st.ent_b;
			IPRS_A_ASN_A: rmux = st.asn_a;
			IPRS_A_ASN_B: rmux = st.asn_b;
			IPRS_A_CACHE_CFG: rmux = st.cache_cfg;
			IPRS_A_STATUS: rmux = status;
			default: begin
				// store slots read back; other holes read zero
				rmux = (i_addr[IPRS_AW-1:IPRS_SW] ==
					IPRS_A_STORE[IPRS_AW-1:IPRS_SW]) ? sbus.rdata : IPRS_ZERO;
			end
		endcase
	end

	always_comb begin
		next_st = st;
		next_st.warm_s = {st.warm_s[0], i_warm_reset};
		next_st.trst_s = {st.trst_s[0], i_test_resetn};
		next_st.pg_s = {st.pg_s[0], i_power_good};
		next_st.fresh = 1'b0;
		next_st.it_flush = 1'b0;
		next_st.dt_flush = 1'b0;
		if (i_rd) begin
			next_st.rdata = rmux;
		end
		if (i_wr) begin
			unique case (i_addr)
				IPRS_A_PRIV_BASE: next_st.priv_base = i_wdata;
				IPRS_A_IU_CTL: next_st.iu_ctl = i_wdata;
				IPRS_A_PROC_CTX: next_st.proc_ctx = i_wdata;
				IPRS_A_DATA_CACHE_CONTROL: next_st.data_cache_control = i_wdata[7:0];
				IPRS_A_MU_CTL: next_st.mu_ctl = i_wdata;
				IPRS_A_TAG_A: next_st.tag_a = i_wdata;
				IPRS_A_TAG_B: next_st.tag_b = i_wdata;
				IPRS_A_ENT_A: next_st.ent_a = i_wdata;
				IPRS_A_ENT_B: next_st.ent_b = i_wdata;
				IPRS_A_ASN_A: next_st.asn_a = i_wdata;
				IPRS_A_ASN_B: next_st.asn_b = i_wdata;
				IPRS_A_ITRANS_IA: next_st.it_flush = 1'b1;
				IPRS_A_DTRANS_IA: next_st.dt_flush = 1'b1;
				IPRS_A_CACHE_CFG: next_st.cache_cfg = i_wdata;
				IPRS_A_STATUS: begin
					if (i_wdata[IPRS_ST_SEQERR]) begin
						next_st.seq_err = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end
		// test reset released while power good is low; set wins over clear
		if (st.trst_s[1] && !st.pg_s[1]) begin
			next_st.seq_err = 1'b1;
		end
		// warm reset overrides a write in the same cycle
		if (warm) begin
			next_st.priv_base = IPRS_ZERO;
			next_st.iu_ctl = IPRS_ZERO;
			next_st.proc_ctx[IPRS_FE_BIT] = 1'b1;
			next_st.cache_cfg = IPRS_ZERO;
		end
	end

	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			st <= '0;
			st.fresh <= 1'b1;
			st.iu_ctl <= IPRS_IUC_RST;
			st.proc_ctx <= IPRS_PROCESS_CONTEXT_RST;
			st.data_cache_control <= IPRS_DCC_RST;
		end else begin
			st <= next_st;
		end
	end

	assign o_rdata = st.rdata;
	assign o_icache_enable = st.iu_ctl[IPRS_ICE_LSB+1:IPRS_ICE_LSB];
	assign o_dcache_ctl = st.data_cache_control;
	assign o_l2_enable = st.cache_cfg[IPRS_L2_BIT];
	assign o_itrans_flush = st.it_flush;
	assign o_dtrans_flush = st.dt_flush;

	////////////////////////////////////////////////////////////////////
	// checks
	property p_ice_rst;
		@(posedge i_mclk) disable iff (!i_resetn)
		st.fresh |-> o_icache_enable == IPRS_ICE_RST &&
			st.iu_ctl == IPRS_IUC_RST;
	endproperty
	a_ice_rst: assert property (p_ice_rst)
		else $error("instruction control wrong after power-up");

	property p_fe_rst;
		@(posedge i_mclk) disable iff (!i_resetn)
		st.fresh |-> st.proc_ctx == IPRS_PROCESS_CONTEXT_RST;
	endproperty
	a_fe_rst: assert property (p_fe_rst)
		else $error("process context wrong after power-up");

	property p_dcc_hi;
		@(posedge i_mclk) disable iff (!i_resetn)
		st.fresh |-> o_dcache_ctl[7:2] == 6'h00;
	endproperty
	a_dcc_hi: assert property (p_dcc_hi)
		else $error("data cache control high bits not cleared");

	property p_dcc_lo;
		@(posedge i_mclk) disable iff (!i_resetn)
		st.fresh |-> o_dcache_ctl[1:0] == 2'h3;
	endproperty
	a_dcc_lo: assert property (p_dcc_lo)
		else $error("data cache control low bits not set");

	property p_clr_rst;
		@(posedge i_mclk) disable iff (!i_resetn)
		st.fresh |-> (st.tag_a | st.tag_b | st.ent_a | st.ent_b | st.asn_a |
			st.asn_b | st.mu_ctl | st.priv_base) == IPRS_ZERO;
	endproperty
	a_clr_rst: assert property (p_clr_rst)
		else $error("translation or base register not cleared");

	sequence s_warm_in;
		$rose(i_warm_reset) && !warm;
	endsequence
	property p_warm;
		@(posedge i_mclk) disable iff (!i_resetn)
		s_warm_in ##2 warm |=> st.priv_base == IPRS_ZERO &&
			st.iu_ctl == IPRS_ZERO && !o_l2_enable &&
			st.proc_ctx[IPRS_FE_BIT];
	endproperty
	a_warm: assert property (p_warm)
		else $error("warm reset did not clear its registers");

	sequence s_itia_wr;
		i_wr && i_addr == IPRS_A_ITRANS_IA;
	endsequence
	property p_itia;
		@(posedge i_mclk) disable iff (!i_resetn)
		s_itia_wr ##1 !i_wr |-> o_itrans_flush ##1 !o_itrans_flush;
	endproperty
	a_itia: assert property (p_itia)
		else $error("invalidate-all write gave no single pulse");

	property p_seqerr;
		@(posedge i_mclk) disable iff (!i_resetn)
		// a clear write in the next cycle may legally drop the flag
		(st.trst_s[1] && !st.pg_s[1]) ##1
			!(i_wr && i_addr == IPRS_A_STATUS) |-> st.seq_err[*2];
	endproperty
	a_seqerr: assert property (p_seqerr)
		else $error("early test reset release not flagged");

	property p_trst_free;
		@(posedge i_mclk) disable iff (!i_resetn)
		(!i_test_resetn && i_wr && i_addr == IPRS_A_PRIV_BASE && !warm) |=>
			st.priv_base == $past(i_wdata);
	endproperty
	a_trst_free: assert property (p_trst_free)
		else $error("writes blocked while test reset asserted");
endmodule : iprs_bank

// ===== tb/iprs_sys_model.sv
// Purpose: system reset logic beside the register bank
// Assumes: power good settles a few cycles after power-up
// Notes: test reset is never let go before power good is seen
`timescale 1ns/10ps
module iprs_sys_model (
	input wire logic i_mclk,
	input wire logic i_release,
	input wire logic i_drop,
	output logic o_power_good,
	output logic o_test_resetn
);
	logic [1:0] pg_cnt;
	initial begin
		pg_cnt = 2'h0;
		o_power_good = 1'b0;
		o_test_resetn = 1'b0;
	end
	always @(posedge i_mclk) begin
		// a supply dip restarts the settle count
		if (i_drop) begin
			pg_cnt <= 2'h0;
		end else if (pg_cnt != 2'h3) begin
			pg_cnt <= pg_cnt + 2'h1;
		end
		o_power_good <= !i_drop && (pg_cnt == 2'h3);
		// release waits on power good seen a cycle earlier
		o_test_resetn <= o_test_resetn |
			(i_release & o_power_good);
	end
endmodule : iprs_sys_model

// ===== tb/testbench.sv
// Purpose: register bank checks through its register port
// Assumes: store slots are written before their read-back is checked
// Notes: firmware-side duties live in the init sequence below
`timescale 1ns/10ps
module testbench;
	import iprs_pkg::*;
	logic i_mclk, i_resetn, i_warm_reset, i_wr, i_rd, rel, drop;
	logic i_test_resetn, i_power_good;
	iprs_addr_t i_addr;
	iprs_word_t i_wdata;
	logic [IPRS_DW-1:0] o_rdata;
	logic [1:0] o_icache_enable;
	logic [7:0] o_dcache_ctl;
	logic o_l2_enable, o_itrans_flush, o_dtrans_flush;
	int error_cnt, num_checks;
	iprs_bank iprs_bank_inst (.i_mclk(i_mclk), .i_resetn(i_resetn),
		.i_warm_reset(i_warm_reset), .i_test_resetn(i_test_resetn),
		.i_power_good(i_power_good), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.o_icache_enable(o_icache_enable), .o_dcache_ctl(o_dcache_ctl),
		.o_l2_enable(o_l2_enable), .o_itrans_flush(o_itrans_flush),
		.o_dtrans_flush(o_dtrans_flush));
	iprs_sys_model iprs_sys_model_inst (.i_mclk(i_mclk), .i_release(rel),
		.i_drop(drop),
		.o_power_good(i_power_good), .o_test_resetn(i_test_resetn));
	////////////////////////////////////////////////////////////////////
	initial begin
		i_mclk = 1'b0;
		forever #20 i_mclk = ~i_mclk;
	end
	task automatic check(input string nm, input iprs_word_t seen,
		input iprs_word_t exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic wr(input iprs_addr_t a, input iprs_word_t d);
		@(posedge i_mclk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_mclk);
		i_wr <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input iprs_addr_t a, output iprs_word_t d);
		@(posedge i_mclk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		#1;
		d = o_rdata;
	endtask : rd
	task automatic test_done();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : test_done
	function automatic iprs_word_t rst_val(input iprs_addr_t a);
		case (a)
			IPRS_A_IU_CTL: rst_val = IPRS_IUC_RST;
			IPRS_A_PROC_CTX: rst_val = IPRS_PROCESS_CONTEXT_RST;
			IPRS_A_DATA_CACHE_CONTROL: rst_val = {24'h00_0000, IPRS_DCC_RST};
			default: rst_val = 32'h0000_0000;
		endcase
	endfunction : rst_val
	////////////////////////////////////////////////////////////////////
	task automatic pwr_reset();
		i_resetn <= 1'b0;
		repeat (6) @(posedge i_mclk);
		i_resetn <= 1'b1;
	endtask : pwr_reset
	task automatic chk_defined();
		iprs_word_t d;
		check("icache_en", {30'h0, o_icache_enable}, 32'h3);
		check("dcache_ctl", {24'h0, o_dcache_ctl}, 32'h3);
		for (int a = 0; a <= 10; a++) begin
			rd(a[7:0], d);
			check("reset value", d,
				rst_val(a[7:0]));
		end
	endtask : chk_defined
	initial begin
		#(40 * 3000);
		error_cnt++;
		test_done();
	end
	initial begin
		iprs_word_t d;
		error_cnt = 0;
		num_checks = 0;
		{i_warm_reset, i_wr, i_rd, rel, drop} = 5'h00;
		i_addr = 8'h00;
		i_wdata = 32'h0000_0000;
		pwr_reset();
		chk_defined();
		// firmware duties; test reset still held
		wr(IPRS_A_ITRANS_IA, 32'h0000_0000);
		check("iflush", {31'h0, o_itrans_flush}, 32'h1);
		wr(IPRS_A_DTRANS_IA, 32'h0000_0000);
		check("dflush", {31'h0, o_dtrans_flush}, 32'h1);
		rd(IPRS_A_STORE + 8'h09, d);
		for (int s = 0; s < 9; s++) begin
			wr(IPRS_A_STORE + s[7:0], 32'hA5A5_0000 + s);
		end
		for (int s = 0; s < 9; s++) begin
			rd(IPRS_A_STORE + s[7:0], d);
			check("store slot", d, 32'hA5A5_0000 + s);
		end
		wr(IPRS_A_PRIV_BASE, 32'h0000_2400);
		rd(IPRS_A_PRIV_BASE, d);
		check("base held", d, 32'h0000_2400);
		rd(IPRS_A_STATUS, d);
		check("status held", d, 32'h0000_0001);
		@(posedge i_mclk);
		rel <= 1'b1;
		repeat (6) @(posedge i_mclk);
		rd(IPRS_A_STATUS, d);
		check("status run", d, 32'h0000_0003);
		// power good dips with test reset released: sticky error
		@(posedge i_mclk);
		drop <= 1'b1;
		repeat (6) @(posedge i_mclk);
		rd(IPRS_A_STATUS, d);
		check("status dip", d, 32'h0000_0006);
		@(posedge i_mclk);
		drop <= 1'b0;
		repeat (8) @(posedge i_mclk);
		rd(IPRS_A_STATUS, d);
		check("status sticky", d, 32'h0000_0007);
		wr(IPRS_A_STATUS, 32'h0000_0004);
		rd(IPRS_A_STATUS, d);
		check("status clear", d, 32'h0000_0003);
		rd(8'h0F, d);
		check("unmapped", d, 32'h0000_0000);
		wr(IPRS_A_DATA_CACHE_CONTROL, 32'hFFFF_FFFF);
		rd(IPRS_A_DATA_CACHE_CONTROL, d);
		check("dc write", d, 32'h0000_00FF);
		wr(IPRS_A_PRIV_BASE, 32'h1234_5600);
		wr(IPRS_A_CACHE_CFG, 32'h0000_0001);
		check("l2 on", {31'h0, o_l2_enable}, 32'h1);
		wr(IPRS_A_PROC_CTX, 32'h0000_0000);
		// warm reset is a level, give the sync flops time
		@(posedge i_mclk);
		i_warm_reset <= 1'b1;
		repeat (5) @(posedge i_mclk);
		i_warm_reset <= 1'b0;
		repeat (4) @(posedge i_mclk);
		rd(IPRS_A_PRIV_BASE, d);
		check("warm base", d, 32'h0000_0000);
		rd(IPRS_A_IU_CTL, d);
		check("warm iu", d, 32'h0000_0000);
		rd(IPRS_A_PROC_CTX, d);
		check("warm fe", d, IPRS_PROCESS_CONTEXT_RST);
		check("warm l2", {31'h0, o_l2_enable}, 32'h0);
		check("warm dc", {24'h0, o_dcache_ctl}, 32'hFF);
		check("warm ice", {30'h0, o_icache_enable}, 32'h0);
		// second power-up restores defined values
		@(posedge i_mclk);
		pwr_reset();
		chk_defined();
		test_done();
	end
endmodule : testbench
